// *** inc/sac_map.svh ***
// timing figures and derived cycle counts for the converter host controller
`ifndef SAC_MAP_SVH
`define SAC_MAP_SVH

`define SAC_CLK_PERIOD_NS 100
`define SAC_SYNC_STAGES 2
`define SAC_RES_BITS 18

// least time rounds up, longest time rounds down, never below one cycle
`define SAC_CEIL(t) (((t) + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS)
`define SAC_FLOOR(t) ((t) / `SAC_CLK_PERIOD_NS)
`define SAC_CYC_MIN(t) ((`SAC_CEIL(t) < 1) ? 1 : `SAC_CEIL(t))
`define SAC_CYC_MAX(t) ((`SAC_FLOOR(t) < 1) ? 1 : `SAC_FLOOR(t))

// pin timing in ns
`define SAC_T_CONV_NS 1520
`define SAC_T_ACQ_NS 400
`define SAC_T_W1_NS 40
`define SAC_T_W2_NS 20
`define SAC_T_SU1_NS 20
`define SAC_T_H1_NS 40
`define SAC_T_W5_NS 50
`define SAC_T_W6_NS 20
`define SAC_T_W7_NS 20
`define SAC_T_EN_NS 20
`define SAC_T_H2_NS 125
`define SAC_T_D5_NS 30
`define SAC_T_SU3_NS 10
`define SAC_T_PD1_NS 45

// cycle counts
`define SAC_CONV_CYC `SAC_CYC_MAX(`SAC_T_CONV_NS)
`define SAC_ACQ_CYC `SAC_CYC_MIN(`SAC_T_ACQ_NS)
`define SAC_W1_CYC `SAC_CYC_MIN(`SAC_T_W1_NS)
`define SAC_SU1_CYC `SAC_CYC_MIN(`SAC_T_SU1_NS)
`define SAC_W6_CYC `SAC_CYC_MIN(`SAC_T_W6_NS)
`define SAC_H2_CYC `SAC_CYC_MIN(`SAC_T_H2_NS)
`define SAC_D5_CYC `SAC_CYC_MIN(`SAC_T_D5_NS)
`define SAC_SU3_CYC `SAC_CYC_MIN(`SAC_T_SU3_NS)
// busy must be visible through the synchroniser before it is trusted
`define SAC_BUSY_SEEN_CYC (`SAC_CYC_MIN(`SAC_T_PD1_NS) + `SAC_SYNC_STAGES)
// strobe low covers enable time plus the data synchroniser
`define SAC_RD_LOW_CYC (`SAC_CYC_MIN(`SAC_T_EN_NS) + `SAC_SYNC_STAGES)
`define SAC_CONV_LIM (`SAC_CONV_CYC + `SAC_SYNC_STAGES)

`endif

// *** inc/sac_pkg.sv ***
// types for the converter host controller
package sac_pkg;

   typedef enum logic [3:0] {
      SAC_IDLE, SAC_CS_SETUP, SAC_CONV_LO, SAC_CONV_HI, SAC_WAIT_BUSY,
      SAC_MSB_WAIT, SAC_SEL_SETUP, SAC_RD_LO, SAC_RD_HI
   } sac_state_type;

   typedef enum logic [1:0] {
      SAC_MODE_FULL, SAC_MODE_HALF, SAC_MODE_EIGHT
   } sac_mode_type;

endpackage : sac_pkg

// *** logic/sac_buf.sv ***
// small valid/ready buffer holding finished conversion words
`timescale 1ns/1ps
module sac_buf #(
   parameter int WIDTH = 18,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wr_ptr_q;
   logic [PW-1:0] rd_ptr_q;
   logic [PW:0] count_q;
   logic do_wr;
   logic do_rd;

   // honest full and empty from the fill count
   assign in_ready = (count_q != (PW+1)'(DEPTH));
   assign out_valid = (count_q != '0);
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   assign out_data = mem_q[rd_ptr_q];

   // storage has no reset, only the pointers and the fill count need one
   always_ff @(posedge CLK) begin
      if (do_wr) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   // pointers wrap at depth
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q <= '0;
      end else begin
         if (do_wr) wr_ptr_q <= (wr_ptr_q == PW'(DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
         if (do_rd) rd_ptr_q <= (rd_ptr_q == PW'(DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
         count_q <= count_q + (PW+1)'(do_wr) - (PW+1)'(do_rd);
      end
   end
endmodule : sac_buf

// *** logic/sac_ctrl.sv ***
// host controller: starts conversions, reads the result, queues the words
// Overview of operation
// - busy low at least 0.4 us before next convert-start
// - convert-start low at least 40 ns, high at least 20 ns
// - chip select low at least 20 ns before convert-start falls
// - no read, read chip select or select change within 40 ns of start
// - chip select falls no later than read strobe, rises no earlier
// - read strobe low at least 50 ns, high at least 20 ns
// - chip select high at least 20 ns before asserting again
// - msb data valid 30 ns after busy falls; first read waits that
// - last read ends at least 125 ns before next convert-start
// - width selects set 10 ns before read strobe falls, held around it
// - edges of one width select at least 50 ns apart
// - narrow select edge never trails the wide select edge
`timescale 1ns/1ps
`include "sac_map.svh"
module sac_ctrl (
   // clock and reset
   input wire logic CLK,
   input wire logic NRST,
   // user request side
   input wire logic START,
   input wire logic [1:0] MODE,
   output logic CONV_TIMEOUT,
   // result stream
   output logic RESULT_VALID,
   input wire logic RESULT_READY,
   output logic [`SAC_RES_BITS-1:0] RESULT,
   // converter pins
   output logic CONVERT_START_N,
   output logic CS_N,
   output logic RD_N,
   output logic WIDE_BUS_SELECT,
   output logic NARROW_SEL,
   input wire logic BUSY,
   input wire logic [`SAC_RES_BITS-1:0] DATA
);
   localparam int DW = `SAC_RES_BITS;
   localparam logic [4:0] SU1_C = 5'(`SAC_SU1_CYC);
   localparam logic [4:0] W1_C = 5'(`SAC_W1_CYC);
   localparam logic [4:0] SEEN_C = 5'(`SAC_BUSY_SEEN_CYC);
   localparam logic [4:0] D5_C = 5'(`SAC_D5_CYC);
   localparam logic [4:0] SU3_C = 5'(`SAC_SU3_CYC);
   localparam logic [4:0] RDL_C = 5'(`SAC_RD_LOW_CYC);
   localparam logic [4:0] W6_C = 5'(`SAC_W6_CYC);
   localparam logic [4:0] CONV_LIM_C = 5'(`SAC_CONV_LIM);
   localparam logic [3:0] ACQ_C = 4'(`SAC_ACQ_CYC);
   localparam logic [3:0] H2_C = 4'(`SAC_H2_CYC);

   sac_pkg::sac_state_type state_q, state_d;
   sac_pkg::sac_mode_type mode_q, mode_in;
   logic [4:0] cnt_q, lim;
   logic [1:0] part_q, last_part;
   logic [4:0] part_w;
   logic [DW-1:0] acc_q, acc_next;
   logic busy_m_q, busy_s_q;
   logic [DW-1:0] data_m_q, data_s_q;
   logic [3:0] busy_low_q, cs_high_q;
   logic convert_start_n_q, cs_q, rd_q, wide_q, narrow_q, tmo_q;
   logic dwell_done, acq_ok, gap_ok, push, tmo, buf_ready, wide_d, narrow_d;

   // pins from the converter cross two flops before any decision
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         busy_m_q <= 1'b0;
         busy_s_q <= 1'b0;
         data_m_q <= '0;
         data_s_q <= '0;
      end else begin
         busy_m_q <= BUSY;
         busy_s_q <= busy_m_q;
         data_m_q <= DATA;
         data_s_q <= data_m_q;
      end
   end

   // dwell per state; the counter restarts on every state change
   assign lim = (state_q == sac_pkg::SAC_CS_SETUP) ? SU1_C :
                (state_q == sac_pkg::SAC_CONV_LO) ? W1_C :
                (state_q == sac_pkg::SAC_CONV_HI) ? SEEN_C :
                (state_q == sac_pkg::SAC_MSB_WAIT) ? D5_C :
                (state_q == sac_pkg::SAC_SEL_SETUP) ? SU3_C :
                (state_q == sac_pkg::SAC_RD_LO) ? RDL_C : W6_C;
   assign dwell_done = (cnt_q == lim - 5'd1);
   assign acq_ok = (busy_low_q >= ACQ_C);
   assign gap_ok = (cs_high_q >= H2_C);

   // portion width per read: device hands out successive portions msb first
   assign last_part = (mode_q == sac_pkg::SAC_MODE_EIGHT) ? 2'd2 :
                      (mode_q == sac_pkg::SAC_MODE_HALF) ? 2'd1 : 2'd0;
   assign part_w = (part_q == last_part && part_q != 2'd0) ? 5'd2 :
                   (mode_q == sac_pkg::SAC_MODE_EIGHT) ? 5'd8 :
                   (mode_q == sac_pkg::SAC_MODE_HALF) ? 5'd16 : 5'd18;
   assign acc_next = (acc_q << part_w) | (data_s_q >> (5'(DW) - part_w));

   // width selects follow the latched mode, held for the whole word
   assign wide_d = (mode_q == sac_pkg::SAC_MODE_FULL);
   assign narrow_d = (mode_q == sac_pkg::SAC_MODE_EIGHT);

   // the unused width code falls back to one full-width read, selects included
   assign mode_in = (MODE == 2'(sac_pkg::SAC_MODE_HALF)) ? sac_pkg::SAC_MODE_HALF :
                    (MODE == 2'(sac_pkg::SAC_MODE_EIGHT)) ? sac_pkg::SAC_MODE_EIGHT :
                    sac_pkg::SAC_MODE_FULL;

   // sequencer: one conversion and its reads per pass
   always_comb begin
      state_d = state_q;
      push = 1'b0;
      tmo = 1'b0;
      case (state_q)
         sac_pkg::SAC_IDLE: begin
            // no start unless the buffer can take the word
            if (START && buf_ready && acq_ok && gap_ok) state_d = sac_pkg::SAC_CS_SETUP;
         end
         sac_pkg::SAC_CS_SETUP: if (dwell_done) state_d = sac_pkg::SAC_CONV_LO;
         sac_pkg::SAC_CONV_LO: if (dwell_done) state_d = sac_pkg::SAC_CONV_HI;
         sac_pkg::SAC_CONV_HI: if (dwell_done) state_d = sac_pkg::SAC_WAIT_BUSY;
         sac_pkg::SAC_WAIT_BUSY: begin
            if (!busy_s_q) begin
               state_d = sac_pkg::SAC_MSB_WAIT;
            end else if (cnt_q == CONV_LIM_C) begin
               // a stuck busy aborts the pass instead of hanging the bus
               tmo = 1'b1;
               state_d = sac_pkg::SAC_IDLE;
            end
         end
         sac_pkg::SAC_MSB_WAIT: if (dwell_done) state_d = sac_pkg::SAC_SEL_SETUP;
         sac_pkg::SAC_SEL_SETUP: if (dwell_done) state_d = sac_pkg::SAC_RD_LO;
         sac_pkg::SAC_RD_LO: if (dwell_done) state_d = sac_pkg::SAC_RD_HI;
         sac_pkg::SAC_RD_HI: begin
            if (dwell_done) begin
               if (part_q == last_part) begin
                  push = 1'b1;
                  state_d = sac_pkg::SAC_IDLE;
               end else begin
                  state_d = sac_pkg::SAC_RD_LO;
               end
            end
         end
         default: state_d = sac_pkg::SAC_IDLE;
      endcase
   end

   // state, counters and word assembly
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         state_q <= sac_pkg::SAC_IDLE;
         cnt_q <= '0;
         part_q <= '0;
         mode_q <= sac_pkg::SAC_MODE_FULL;
         acc_q <= '0;
      end else begin
         state_q <= state_d;
         cnt_q <= (state_d != state_q) ? 5'd0 : cnt_q + 5'd1;
         if (state_q == sac_pkg::SAC_IDLE) begin
            part_q <= '0;
            mode_q <= mode_in;
         end else if (state_q == sac_pkg::SAC_RD_HI && state_d == sac_pkg::SAC_RD_LO) begin
            part_q <= part_q + 2'd1;
         end
         if (state_q == sac_pkg::SAC_RD_LO && dwell_done) acc_q <= acc_next;
      end
   end

   // time since busy fell and since chip select rose, saturating
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         busy_low_q <= 4'hF;
         cs_high_q <= 4'hF;
      end else begin
         busy_low_q <= busy_s_q ? 4'h0 : ((busy_low_q == 4'hF) ? busy_low_q : busy_low_q + 4'h1);
         cs_high_q <= !cs_q ? 4'h0 : ((cs_high_q == 4'hF) ? cs_high_q : cs_high_q + 4'h1);
      end
   end

   // pin drivers are registered copies of the next state
   always_ff @(posedge CLK) begin
      if (!NRST) begin
         convert_start_n_q <= 1'b1;
         cs_q <= 1'b1;
         rd_q <= 1'b1;
         wide_q <= 1'b1;
         narrow_q <= 1'b0;
         tmo_q <= 1'b0;
      end else begin
         convert_start_n_q <= (state_d != sac_pkg::SAC_CONV_LO);
         cs_q <= (state_d == sac_pkg::SAC_IDLE);
         rd_q <= (state_d != sac_pkg::SAC_RD_LO);
         tmo_q <= tmo;
         // selects move only ahead of the first read of a word
         if (state_d == sac_pkg::SAC_SEL_SETUP && part_q == 2'd0) begin
            wide_q <= wide_d;
            narrow_q <= narrow_d;
         end
      end
   end

   assign CONVERT_START_N = convert_start_n_q;
   assign CS_N = cs_q;
   assign RD_N = rd_q;
   assign WIDE_BUS_SELECT = wide_q;
   assign NARROW_SEL = narrow_q;
   assign CONV_TIMEOUT = tmo_q;

   // two words of slack so a stalled receiver loses nothing
   sac_buf #(.WIDTH(DW), .DEPTH(2)) u_buf (
      .CLK(CLK),
      .NRST(NRST),
      .in_valid(push),
      .in_ready(buf_ready),
      .in_data(acc_q),
      .out_valid(RESULT_VALID),
      .out_ready(RESULT_READY),
      .out_data(RESULT)
   );

   // checks on the pin sequence
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);

   a_acq_gap: assert property ($fell(CONVERT_START_N) |-> busy_low_q > ACQ_C)
      else $error("convert start before acquisition time");
   a_convert_start_n_pulse: assert property ($fell(CONVERT_START_N) |=> CONVERT_START_N [*3])
      else $error("convert start pulse shape wrong");
   a_cs_setup: assert property ($fell(CONVERT_START_N) |-> !CS_N && !$past(CS_N))
      else $error("chip select setup to convert start too short");
   a_start_quiet: assert property ($fell(CONVERT_START_N) |->
      (RD_N && $stable(WIDE_BUS_SELECT) && $stable(NARROW_SEL)) [*4])
      else $error("read activity too soon after convert start");
   a_cs_rd_order: assert property (!RD_N |-> !CS_N && !$past(CS_N))
      else $error("read strobe outside chip select");
   a_rd_low_width: assert property ($fell(RD_N) |-> !RD_N [*3] ##1 RD_N)
      else $error("read strobe low width wrong");
   a_cs_high_width: assert property ($rose(CS_N) |-> CS_N [*2])
      else $error("chip select high too short");
   a_msb_wait: assert property ($fell(RD_N) |-> !busy_s_q && busy_low_q >= 4'(D5_C + 5'd1))
      else $error("first read too soon after busy fell");
   a_sel_setup: assert property ($fell(RD_N) |-> $stable(WIDE_BUS_SELECT)
      && $stable(NARROW_SEL) ##1 $stable(WIDE_BUS_SELECT) && $stable(NARROW_SEL))
      else $error("width select moved around read strobe");
   a_sel_spacing: assert property ($changed(NARROW_SEL) || $changed(WIDE_BUS_SELECT) |=>
      ($stable(NARROW_SEL) && $stable(WIDE_BUS_SELECT)) [*3])
      else $error("width select edges too close");
   a_word_parts: assert property (push |-> part_q == last_part
      && (mode_q != sac_pkg::SAC_MODE_EIGHT || part_q == 2'd2))
      else $error("word pushed with wrong read count");
   a_busy_bound: assert property (state_q == sac_pkg::SAC_WAIT_BUSY && busy_s_q
      && cnt_q == CONV_LIM_C |=> state_q == sac_pkg::SAC_IDLE && CONV_TIMEOUT)
      else $error("stuck busy not aborted");

   c_full: cover property (push && mode_q == sac_pkg::SAC_MODE_FULL);
   c_half: cover property (push && mode_q == sac_pkg::SAC_MODE_HALF);
   c_eight: cover property (push && mode_q == sac_pkg::SAC_MODE_EIGHT);
   c_stall: cover property (!buf_ready && START && state_q == sac_pkg::SAC_IDLE);
endmodule : sac_ctrl

// *** test/sac_adc_model.sv ***
// behavioural converter model facing the host controller pins
`timescale 1ns/1ps
module sac_adc_model (
   // control pins from the host
   input wire logic CONVERT_START_N,
   input wire logic CS_N,
   input wire logic RD_N,
   input wire logic WIDE_BUS_SELECT,
   input wire logic NARROW_SEL,
   // bench controls
   input wire logic [17:0] sample,
   input wire logic [31:0] conv_ns,
   input wire logic hang,
   // pins back to the host
   output logic BUSY,
   output logic [17:0] DATA,
   // bench observation
   output int nconv,
   output int rd_cnt,
   output int viol
);
   logic [17:0] word_q;
   int part;
   realtime t_cs = -1.0e6, t_csh = -1.0e6, t_cv = -1.0e6, t_bf = -1.0e6;
   realtime t_rdr = -1.0e6, t_rdf = -1.0e6, t_sel = -1.0e6;

   // far past start times so the first edges see no false gap
   initial begin
      BUSY = 1'b0;
      DATA = 18'h0_0000;
      nconv = 0;
      rd_cnt = 0;
      viol = 0;
      part = 0;
      word_q = 18'h0_0000;
   end

   // portion served per read; unused lines carry garbage, not zeros
   function automatic logic [17:0] portion(int p);
      logic [17:0] w;
      w = ~word_q;
      if (WIDE_BUS_SELECT === 1'b1) return word_q;
      if (NARROW_SEL === 1'b1) begin
         if (p < 2) w[17:10] = word_q[17-8*p -: 8];
         else w[17:16] = word_q[1:0];
      end else if (p == 0) w[17:2] = word_q[17:2];
      else w[17:16] = word_q[1:0];
      return w;
   endfunction : portion

   // conversion: busy shortly after the start edge, low after conv_ns, or after 3000 ns while hang is set
   always @(negedge CONVERT_START_N) begin
      if (CS_N !== 1'b0 || $realtime - t_cs < 20) viol++;
      if ($realtime - t_bf < 400 || $realtime - t_rdr < 125) viol++;
      t_cv = $realtime;
      part = 0;
      word_q = 18'(sample + nconv);
      nconv++;
      #30 BUSY = 1'b1;
      #(hang ? 3000 : conv_ns) BUSY = 1'b0;
      t_bf = $realtime;
   end

   // start strobe low width
   always @(posedge CONVERT_START_N) if ($realtime - t_cv < 40) viol++;

   // chip select spacing and order against the read strobe
   always @(negedge CS_N) begin
      if ($realtime - t_csh < 20) viol++;
      t_cs = $realtime;
   end
   always @(posedge CS_N) begin
      if (RD_N === 1'b0) viol++;
      t_csh = $realtime;
   end

   // read strobe: checks, then data after the enable time
   always @(negedge RD_N) begin
      if (CS_N !== 1'b0 || BUSY !== 1'b0) viol++;
      if ($realtime - t_cv < 40 || $realtime - t_bf < 30) viol++;
      if ($realtime - t_rdr < 20 || $realtime - t_sel < 10) viol++;
      t_rdf = $realtime;
      rd_cnt++;
      #15 DATA = portion(part);
   end
   // released bus shows the inverse, never the last word
   always @(posedge RD_N) begin
      if ($realtime - t_rdf < 50) viol++;
      t_rdr = $realtime;
      part++;
      #5 DATA = ~DATA;
   end

   // width select spacing; both moving on one edge counts once
   always @(WIDE_BUS_SELECT or NARROW_SEL) begin
      if ($realtime != t_sel && $realtime - t_sel < 50) viol++;
      t_sel = $realtime;
   end

   // a select edge during a read moves the served portion
   always @(WIDE_BUS_SELECT or NARROW_SEL)
      if (RD_N === 1'b0) DATA <= #15 portion(part);
endmodule : sac_adc_model

// *** test/tb_sac_ctrl.sv ***
// self-checking bench for the converter host controller
`timescale 1ns/1ps
module tb_sac_ctrl;
   logic CLK = 1'b0, NRST = 1'b0, START = 1'b0, RESULT_READY = 1'b0, hang = 1'b0;
   logic [1:0] MODE = 2'h0;
   logic [17:0] sample = 18'h0_0000;
   int conv_ns = 1200;
   logic CONV_TIMEOUT, RESULT_VALID, CONVERT_START_N, CS_N, RD_N, WIDE_BUS_SELECT;
   logic NARROW_SEL, BUSY;
   logic [17:0] RESULT, DATA;
   int nconv, rd_cnt, viol;
   int fails = 0, checks_done = 0;

   always #50 CLK = ~CLK;

   sac_ctrl dut_u (.CLK(CLK), .NRST(NRST), .START(START), .MODE(MODE),
      .CONV_TIMEOUT(CONV_TIMEOUT), .RESULT_VALID(RESULT_VALID),
      .RESULT_READY(RESULT_READY), .RESULT(RESULT), .CONVERT_START_N(CONVERT_START_N),
      .CS_N(CS_N), .RD_N(RD_N), .WIDE_BUS_SELECT(WIDE_BUS_SELECT),
      .NARROW_SEL(NARROW_SEL), .BUSY(BUSY), .DATA(DATA));
   sac_adc_model adc_u (.CONVERT_START_N(CONVERT_START_N), .CS_N(CS_N), .RD_N(RD_N),
      .WIDE_BUS_SELECT(WIDE_BUS_SELECT), .NARROW_SEL(NARROW_SEL), .sample(sample),
      .conv_ns(conv_ns), .hang(hang), .BUSY(BUSY), .DATA(DATA), .nconv(nconv),
      .rd_cnt(rd_cnt), .viol(viol));

   task automatic chk(string what, logic [17:0] exp, logic [17:0] got);
      checks_done++;
      if (got !== exp) begin
         fails++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // bounded wait, judged at the falling edge where outputs are settled
   task automatic wait_for(string what, ref logic sig, input logic val, input int lim);
      int k;
      k = 0;
      while (sig !== val && k < lim) begin
         @(negedge CLK);
         k++;
      end
      chk(what, 18'(val), 18'(sig));
   endtask : wait_for

   task automatic final_report;
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   task automatic pop_word(logic [17:0] exp);
      chk("result", exp, RESULT);
      @(posedge CLK) RESULT_READY <= 1'b1;
      @(posedge CLK) RESULT_READY <= 1'b0;
      @(negedge CLK);
   endtask : pop_word

   // one word in the given width mode, read count and selects judged
   task automatic t_word(logic [1:0] m, logic [17:0] s, int cns);
      int n0, r0;
      n0 = nconv;
      r0 = rd_cnt;
      @(posedge CLK) {MODE, sample, conv_ns, START} <= {m, s, cns, 1'b1};
      wait_for("cs low", CS_N, 1'b0, 20);
      @(posedge CLK) START <= 1'b0;
      wait_for("result valid", RESULT_VALID, 1'b1, 60);
      chk("reads", 18'((m == 2'h1) ? 2 : (m == 2'h2) ? 3 : 1), 18'(rd_cnt - r0));
      chk("wide select", 18'(m != 2'h1 && m != 2'h2), 18'(WIDE_BUS_SELECT));
      chk("narrow select", 18'(m == 2'h2), 18'(NARROW_SEL));
      chk("conversions", 18'h0_0001, 18'(nconv - n0));
      pop_word(18'(s + n0));
      chk("valid after pop", 18'h0_0000, 18'(RESULT_VALID));
      $display("test word mode %0d done", m);
   endtask : t_word

   // back-to-back conversions with a stalled reader until the buffer refuses
   task automatic t_fill;
      int n0;
      n0 = nconv;
      @(posedge CLK) {MODE, sample, conv_ns, START} <= {2'h1, 18'h2_AAAA, 32'd1000, 1'b1};
      repeat (150) @(posedge CLK);
      START <= 1'b0;
      @(negedge CLK);
      chk("conversions while full", 18'h0_0002, 18'(nconv - n0));
      pop_word(18'(18'h2_AAAA + n0));
      pop_word(18'(18'h2_AAAA + n0 + 1));
      chk("valid after drain", 18'h0_0000, 18'(RESULT_VALID));
      $display("test fill and drain done");
   endtask : t_fill

   // busy held high for 3000 ns, past the wait limit, must abort the pass with a one-cycle pulse
   task automatic t_timeout;
      @(posedge CLK) {START, hang} <= 2'b11;
      wait_for("cs low", CS_N, 1'b0, 20);
      @(posedge CLK) START <= 1'b0;
      wait_for("timeout pulse", CONV_TIMEOUT, 1'b1, 40);
      @(negedge CLK);
      chk("timeout one cycle", 18'h0_0000, 18'(CONV_TIMEOUT));
      chk("no word", 18'h0_0000, 18'(RESULT_VALID));
      chk("cs released", 18'h0_0001, 18'(CS_N));
      chk("no read", 18'h0_0001, 18'(RD_N));
      hang <= 1'b0;
      repeat (35) @(posedge CLK);
      $display("test timeout done");
   endtask : t_timeout

   // watchdog sized well beyond the few hundred cycles the tests take
   initial begin
      #300000;
      fails++;
      final_report();
   end

   initial begin
      repeat (4) @(posedge CLK);
      @(negedge CLK);
      chk("idle pins", 18'h0_000E, 18'({CONVERT_START_N, CS_N, RD_N, NARROW_SEL}));
      chk("idle flags", 18'h0_0004, 18'({WIDE_BUS_SELECT, RESULT_VALID, CONV_TIMEOUT}));
      @(posedge CLK) NRST <= 1'b1;
      $display("test reset done");
      t_word(2'h0, 18'h3_FFFF, 1520);
      t_word(2'h1, 18'h2_5A5A, 1200);
      t_word(2'h2, 18'h1_2345, 800);
      t_word(2'h3, 18'h0_0001, 300);
      t_fill();
      t_timeout();
      chk("host timing faults", 18'h0_0000, 18'(viol));
      chk("select and end faults", 18'h0_0000, 18'(viol));
      final_report();
   end
endmodule : tb_sac_ctrl
